// ==== hsnvm_pkg.sv ====
package hsnvm_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int T_LOAD_NS = 120000;      // 120 us word load and mode entry
    localparam int T_WRITE_NS = 14000000;   // 14 ms non-volatile write
    localparam int T_WINDOW_NS = 10000000;  // 10 ms entry window after power-up
    localparam int LOAD_CYC = (T_LOAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WINDOW_CYC = T_WINDOW_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Addresses, commands and fields
    // ----------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h44;
    localparam logic [7:0] REG_HUM_RD = 8'h06;
    localparam logic [7:0] REG_TEMP_RD = 8'h11;
    localparam logic [7:0] REG_ID_HI = 8'h1e;
    localparam logic [7:0] REG_ID_LO = 8'h1f;
    localparam logic [7:0] REG_HUM_WR = 8'h46;
    localparam logic [7:0] REG_TEMP_WR = 8'h51;
    localparam logic [7:0] CMD_ENTER = 8'ha0;
    localparam logic [7:0] CMD_EXIT = 8'h80;
    localparam logic [7:0] CMD_ARG = 8'h00;
    localparam logic [7:0] TX_IDLE = 8'hff;
    localparam int RES_MSB = 11;
    localparam int RES_LSB = 10;
    localparam logic [1:0] RES_DEFAULT = 2'h3;
    localparam logic [15:0] CFG_OTHER_DEFAULT = 16'h0000;
    localparam logic [1:0] IDX_HUM = 2'h0;
    localparam logic [1:0] IDX_TEMP = 2'h1;
    localparam logic [1:0] IDX_ID_HI = 2'h2;
    localparam logic [1:0] IDX_ID_LO = 2'h3;
    localparam logic [1:0] MEAS_VALID = 2'h0;
    localparam logic [1:0] MEAS_STALE = 2'h1;
    localparam logic [3:0] RES_BITS_8 = 4'h8;
    localparam logic [3:0] RES_BITS_10 = 4'ha;
    localparam logic [3:0] RES_BITS_12 = 4'hc;
    localparam logic [3:0] RES_BITS_14 = 4'he;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [15:0] hsnvm_word_t;
    typedef struct packed {
        logic [13:0] hum;
        logic [13:0] temp;
    } hsnvm_meas_s;
    typedef struct packed {
        hsnvm_word_t hum;
        hsnvm_word_t temp;
    } hsnvm_cfg_s;
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } hsnvm_pinev_s;
    typedef enum logic [4:0] {
        BUS_IDLE = 5'b00001,
        BUS_RECV = 5'b00010,
        BUS_ACK = 5'b00100,
        BUS_SEND = 5'b01000,
        BUS_MACK = 5'b10000
    } hsnvm_bus_e;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [3:0] resBits(input logic [1:0] code);
        case (code)
            2'h0: resBits = RES_BITS_8;
            2'h1: resBits = RES_BITS_10;
            2'h2: resBits = RES_BITS_12;
            default: resBits = RES_BITS_14;
        endcase
    endfunction : resBits

    function automatic logic isRdAddr(input logic [7:0] a);
        isRdAddr = (a == REG_HUM_RD) || (a == REG_TEMP_RD) || (a == REG_ID_HI) ||
            (a == REG_ID_LO);
    endfunction : isRdAddr

    function automatic logic isWrAddr(input logic [7:0] a);
        isWrAddr = (a == REG_HUM_WR) || (a == REG_TEMP_WR);
    endfunction : isWrAddr

    function automatic logic [1:0] regIdx(input logic [7:0] a);
        case (a)
            REG_HUM_RD, REG_HUM_WR: regIdx = IDX_HUM;
            REG_TEMP_RD, REG_TEMP_WR: regIdx = IDX_TEMP;
            REG_ID_HI: regIdx = IDX_ID_HI;
            default: regIdx = IDX_ID_LO;
        endcase
    endfunction : regIdx

    // Status in the top two bits, humidity code below
    function automatic hsnvm_word_t humWord(input logic [1:0] st, input logic [13:0] h);
        humWord = {st, h};
    endfunction : humWord

    // Temperature code left-aligned, two padding bits read as zero
    function automatic hsnvm_word_t tempWord(input logic [13:0] t);
        tempWord = {t, 2'h0};
    endfunction : tempWord

endpackage : hsnvm_pkg

// ==== hsnvm_i2c_pins.sv ====
`timescale 1ns/1ps
module hsnvm_i2c_pins
    import hsnvm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output hsnvm_pinev_s ev
);
    typedef struct packed {
        logic sclMeta;
        logic sclSync;
        logic sclLast;
        logic sdaMeta;
        logic sdaSync;
        logic sdaLast;
        hsnvm_pinev_s ev;
    } hsnvm_pins_s;

    hsnvm_pins_s s_q;
    hsnvm_pins_s s_d;

    // ----------------------------------------------------------------
    // Synchronise both pins, then detect edges and bus conditions
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.sclMeta = sclIn;
        s_d.sclSync = s_q.sclMeta;
        s_d.sclLast = s_q.sclSync;
        s_d.sdaMeta = sdaIn;
        s_d.sdaSync = s_q.sdaMeta;
        s_d.sdaLast = s_q.sdaSync;
        // Edges are taken past the second stage only, never the first
        s_d.ev.rise = s_q.sclSync && !s_q.sclLast;
        s_d.ev.fall = !s_q.sclSync && s_q.sclLast;
        s_d.ev.start = s_q.sclSync && s_q.sclLast && s_q.sdaLast && !s_q.sdaSync;
        s_d.ev.stop = s_q.sclSync && s_q.sclLast && !s_q.sdaLast && s_q.sdaSync;
        s_d.ev.sda = s_q.sdaSync;
    end

    // Idle bus is high on both lines
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '{sclMeta: 1'b1, sclSync: 1'b1, sclLast: 1'b1, sdaMeta: 1'b1,
                sdaSync: 1'b1, sdaLast: 1'b1, ev: '{sda: 1'b1, default: 1'b0}};
        end else begin
            s_q <= s_d;
        end
    end

    assign ev = s_q.ev;

endmodule : hsnvm_i2c_pins

// ==== hsnvm_store.sv ====
`timescale 1ns/1ps
module hsnvm_store
    import hsnvm_pkg::*;
#(
    parameter hsnvm_word_t CFG_OTHER = CFG_OTHER_DEFAULT,
    parameter hsnvm_word_t ID_UPPER = 16'h5a3c,  // Arbitrary value
    parameter hsnvm_word_t ID_LOWER = 16'h0f1e   // Arbitrary value
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wrEn,
    input wire logic [1:0] wrIdx,
    input hsnvm_word_t wrData,
    input wire logic [1:0] rdIdx,
    output hsnvm_word_t rdData,
    output hsnvm_cfg_s cfg
);
    localparam hsnvm_word_t CFG_RESET = (CFG_OTHER & ~(16'h0003 << RES_LSB)) |
        (16'(RES_DEFAULT) << RES_LSB);

    typedef struct packed {
        logic [3:0][15:0] mem;
    } hsnvm_store_s;

    hsnvm_store_s s_q;
    hsnvm_store_s s_d;

    // ----------------------------------------------------------------
    // Word store: two writable resolution words, two fixed id words
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Identifier words cannot be overwritten by a stray write
        if (wrEn && (wrIdx == IDX_HUM || wrIdx == IDX_TEMP)) begin
            s_d.mem[wrIdx] = wrData;
        end
    end

    // Contents reload on reset; a real part would keep them in the array
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q.mem <= {ID_LOWER, ID_UPPER, CFG_RESET, CFG_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdData = s_q.mem[rdIdx];
    assign cfg = '{hum: s_q.mem[IDX_HUM], temp: s_q.mem[IDX_TEMP]};

    a_store_write: assert property (@(posedge clk_sys) disable iff (rst)
        wrEn && wrIdx == IDX_TEMP |=> s_q.mem[IDX_TEMP] == $past(wrData))
        else $error("resolution word not stored");

    a_id_fixed: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> s_q.mem[IDX_ID_HI] == ID_UPPER && s_q.mem[IDX_ID_LO] == ID_LOWER)
        else $error("identifier words changed");

endmodule : hsnvm_store

// ==== hsnvm_top.sv ====
`timescale 1ns/1ps
module hsnvm_top
    import hsnvm_pkg::*;
#(
    parameter int LOAD_CYCLES = LOAD_CYC,
    parameter int WRITE_CYCLES = WRITE_CYC,
    parameter int WINDOW_CYCLES = WINDOW_CYC,
    parameter logic [6:0] I2C_ADDR = DEV_ADDR
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input hsnvm_meas_s meas,
    input wire logic measDone,
    output logic progMode,
    output logic nvmBusy,
    output logic [3:0] humResBits,
    output logic [3:0] tempResBits
);
    localparam int CNT_MAX = (WRITE_CYCLES > WINDOW_CYCLES) ? WRITE_CYCLES : WINDOW_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + 1);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    if (LOAD_CYCLES < 1 || WRITE_CYCLES < 1 || WINDOW_CYCLES < 1) begin : g_bad_count
        $error("hsnvm_top: delay counts must be at least one cycle");
    end

    typedef struct packed {
        hsnvm_bus_e st;
        logic [3:0] bitCnt;
        logic [7:0] sh;
        logic isAddr;
        logic rw;
        logic [2:0] byteIdx;
        logic [2:0][7:0] rx;
        logic sdaOut;
        logic sdaOe;
        logic progMode;
        logic [CNT_W-1:0] busyCnt;
        logic busy;
        logic loadPend;
        logic rdReady;
        logic [1:0] rdIdx;
        hsnvm_word_t rdBuf;
        logic [CNT_W-1:0] winCnt;
        logic winOpen;
        hsnvm_meas_s meas;
        logic stale;
        logic [3:0] humRes;
        logic [3:0] tempRes;
        logic wrEn;
        logic [1:0] wrIdx;
        hsnvm_word_t wrData;
    } hsnvm_top_s;

    hsnvm_top_s s_q;
    hsnvm_top_s s_d;
    hsnvm_pinev_s ev;
    hsnvm_word_t storeRd;
    hsnvm_cfg_s cfg;
    logic cmdGo;
    logic argOk;
    logic [7:0] statByte;
    logic [7:0] txCur;

    // ----------------------------------------------------------------
    // Pin front end and word store
    // ----------------------------------------------------------------
    hsnvm_i2c_pins u_pins (
        .clk_sys(clk_sys),
        .rst(rst),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .ev(ev)
    );
    hsnvm_store u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .wrEn(s_q.wrEn),
        .wrIdx(s_q.wrIdx),
        .wrData(s_q.wrData),
        .rdIdx(s_q.rdIdx),
        .rdData(storeRd),
        .cfg(cfg)
    );

    // ----------------------------------------------------------------
    // Byte served for a read transfer at a given position
    // ----------------------------------------------------------------
    function automatic logic [7:0] txByte(input logic prog, input logic [2:0] idx,
        input logic [7:0] stat, input hsnvm_word_t buf_w, input hsnvm_meas_s m,
        input logic stl);
        hsnvm_word_t hw;
        hsnvm_word_t tw;
        hw = humWord(stl ? MEAS_STALE : MEAS_VALID, m.hum);
        tw = tempWord(m.temp);
        txByte = TX_IDLE;
        if (prog) begin
            case (idx)
                3'h0: txByte = stat;
                3'h1: txByte = buf_w[15:8];
                3'h2: txByte = buf_w[7:0];
                default: txByte = TX_IDLE;
            endcase
        end else begin
            case (idx)
                3'h0: txByte = hw[15:8];
                3'h1: txByte = hw[7:0];
                3'h2: txByte = tw[15:8];
                3'h3: txByte = tw[7:0];
                default: txByte = TX_IDLE;
            endcase
        end
    endfunction : txByte

    // Command is complete only after exactly three written bytes
    assign cmdGo = ev.stop && !s_q.rw && !s_q.isAddr && s_q.byteIdx == 3'h3;
    assign argOk = s_q.rx[1] == CMD_ARG && s_q.rx[2] == CMD_ARG;
    assign statByte = {6'h00, s_q.rdReady, s_q.busyCnt != '0};
    assign txCur = txByte(s_q.progMode, s_q.byteIdx, statByte, s_q.rdBuf, s_q.meas,
        s_q.stale);

    // ----------------------------------------------------------------
    // Bus engine, command execution and timers
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.wrEn = 1'b0;
        // Bit-level transfer; SDA changes after a falling SCL edge, or is released on start and stop
        case (s_q.st)
            BUS_IDLE: begin
                s_d.sdaOe = 1'b0;
            end
            BUS_RECV: begin
                if (ev.rise) begin
                    s_d.sh = {s_q.sh[6:0], ev.sda};
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                end else if (ev.fall && s_q.bitCnt == 4'h8) begin
                    s_d.bitCnt = 4'h0;
                    if (s_q.isAddr) begin
                        s_d.isAddr = 1'b0;
                        s_d.rw = s_q.sh[0];
                        s_d.st = (s_q.sh[7:1] == I2C_ADDR) ? BUS_ACK : BUS_IDLE;
                        s_d.sdaOe = s_q.sh[7:1] == I2C_ADDR;
                    end else begin
                        if (s_q.byteIdx < 3'h3) begin
                            s_d.rx[s_q.byteIdx[1:0]] = s_q.sh;
                        end
                        if (s_q.byteIdx != 3'h7) begin
                            s_d.byteIdx = s_q.byteIdx + 3'h1;
                        end
                        s_d.st = BUS_ACK;
                        s_d.sdaOe = 1'b1;
                    end
                end
            end
            BUS_ACK: begin
                if (ev.fall) begin
                    if (s_q.rw) begin
                        s_d.st = BUS_SEND;
                        s_d.sdaOe = !txCur[7];
                        s_d.sh = {txCur[6:0], 1'b0};
                        s_d.bitCnt = 4'h1;
                        s_d.byteIdx = s_q.byteIdx + 3'h1;
                        s_d.stale = s_q.stale || !s_q.progMode;
                    end else begin
                        s_d.st = BUS_RECV;
                        s_d.sdaOe = 1'b0;
                    end
                end
            end
            BUS_SEND: begin
                if (ev.fall) begin
                    if (s_q.bitCnt == 4'h8) begin
                        s_d.st = BUS_MACK;
                        s_d.sdaOe = 1'b0;
                    end else begin
                        s_d.sdaOe = !s_q.sh[7];
                        s_d.sh = {s_q.sh[6:0], 1'b0};
                        s_d.bitCnt = s_q.bitCnt + 4'h1;
                    end
                end
            end
            BUS_MACK: begin
                // Host NACK ends the read; ACK asks for one more byte
                if (ev.rise && ev.sda) begin
                    s_d.st = BUS_IDLE;
                end else if (ev.fall) begin
                    s_d.st = BUS_SEND;
                    s_d.sdaOe = !txCur[7];
                    s_d.sh = {txCur[6:0], 1'b0};
                    s_d.bitCnt = 4'h1;
                    if (s_q.byteIdx != 3'h7) begin
                        s_d.byteIdx = s_q.byteIdx + 3'h1;
                    end
                end
            end
            default: begin
                s_d.st = BUS_IDLE;
                s_d.sdaOe = 1'b0;
            end
        endcase
        if (ev.start) begin
            s_d.st = BUS_RECV;
            s_d.isAddr = 1'b1;
            s_d.rw = 1'b0;
            s_d.bitCnt = 4'h0;
            s_d.byteIdx = 3'h0;
            s_d.sdaOe = 1'b0;
        end
        if (ev.stop) begin
            s_d.st = BUS_IDLE;
            s_d.sdaOe = 1'b0;
        end
        // Busy countdown; a pending load lands in the buffer at its end
        if (s_q.busyCnt != '0) begin
            s_d.busyCnt = s_q.busyCnt - CNT_W'(1);
            if (s_q.busyCnt == CNT_W'(1) && s_q.loadPend) begin
                s_d.rdBuf = storeRd;
                s_d.loadPend = 1'b0;
                s_d.rdReady = 1'b1;
            end
        end
        // Entry is honoured only inside the window after power-up
        if (s_q.winOpen) begin
            s_d.winCnt = s_q.winCnt + CNT_W'(1);
            s_d.winOpen = s_q.winCnt < CNT_W'(WINDOW_CYCLES - 1);
        end
        // Commands while busy are dropped; the host owns the wait
        if (cmdGo) begin
            if (s_q.rx[0] == CMD_ENTER && argOk && s_q.winOpen && !s_q.progMode) begin
                s_d.progMode = 1'b1;
                s_d.busyCnt = CNT_W'(LOAD_CYCLES);
                s_d.rdReady = 1'b0;
            end else if (s_q.progMode && s_q.busyCnt == '0) begin
                if (s_q.rx[0] == CMD_EXIT && argOk) begin
                    s_d.progMode = 1'b0;
                end else if (isRdAddr(s_q.rx[0])) begin
                    s_d.rdIdx = regIdx(s_q.rx[0]);
                    s_d.loadPend = 1'b1;
                    s_d.rdReady = 1'b0;
                    s_d.busyCnt = CNT_W'(LOAD_CYCLES);
                end else if (isWrAddr(s_q.rx[0])) begin
                    s_d.wrEn = 1'b1;
                    s_d.wrIdx = regIdx(s_q.rx[0]);
                    s_d.wrData = {s_q.rx[1], s_q.rx[2]};
                    s_d.busyCnt = CNT_W'(WRITE_CYCLES);
                end
            end
        end
        // A fresh result overrides a fetch in the same cycle
        if (measDone) begin
            s_d.meas = meas;
            s_d.stale = 1'b0;
        end
        // Field decode for each channel on its own word
        s_d.humRes = resBits(cfg.hum[RES_MSB:RES_LSB]);
        s_d.tempRes = resBits(cfg.temp[RES_MSB:RES_LSB]);
        s_d.busy = s_d.busyCnt != '0; // Kept in a flop so the pin has no compare behind it
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '{st: BUS_IDLE, humRes: RES_BITS_14, tempRes: RES_BITS_14,
                winOpen: 1'b1, stale: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sdaOut = s_q.sdaOut;
    assign sdaOe = s_q.sdaOe;
    assign progMode = s_q.progMode;
    assign nvmBusy = s_q.busy;
    assign humResBits = s_q.humRes;
    assign tempResBits = s_q.tempRes;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_res_default: assert property (@(posedge clk_sys) disable iff (rst)
        $past(rst) |-> humResBits == RES_BITS_14 && tempResBits == RES_BITS_14)
        else $error("resolution not at default after reset");

    a_res_decode: assert property (@(posedge clk_sys) disable iff (rst)
        !$past(rst) |-> humResBits == resBits($past(cfg.hum[RES_MSB:RES_LSB])) &&
        tempResBits == resBits($past(cfg.temp[RES_MSB:RES_LSB])))
        else $error("resolution field decoded wrongly");

    a_read_load: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.loadPend && s_q.busyCnt == CNT_W'(1) |=> s_q.rdReady &&
        s_q.rdBuf == $past(storeRd))
        else $error("read word not loaded at end of delay");

    a_rdbuf_hold: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.loadPend && s_q.busyCnt > CNT_W'(1) |=> $stable(s_q.rdBuf) && !s_q.rdReady)
        else $error("read buffer changed during load");

    a_exit_prog: assert property (@(posedge clk_sys) disable iff (rst)
        cmdGo && s_q.progMode && s_q.busyCnt == '0 && s_q.rx[0] == CMD_EXIT && argOk
        |=> !s_q.progMode ##1 !s_q.progMode)
        else $error("exit command did not leave programming mode");

    a_enter_window: assert property (@(posedge clk_sys) disable iff (rst)
        !s_q.winOpen && !s_q.progMode |=> !s_q.progMode)
        else $error("programming mode entered after window");

    a_meas_pad: assert property (@(posedge clk_sys) disable iff (rst)
        !s_q.progMode && s_q.byteIdx == 3'h3 |-> txCur == {s_q.meas.temp[5:0], 2'h0})
        else $error("temperature low byte laid out wrongly");

    a_sda_release: assert property (@(posedge clk_sys) disable iff (rst)
        ev.stop |=> !sdaOe && s_q.st == BUS_IDLE)
        else $error("data line still driven after stop");

endmodule : hsnvm_top

// ==== hsnvm_host.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Bus host model, bit period 20 clocks, SDA pulled up when released
// ----------------------------------------------------------------
module hsnvm_host
    import hsnvm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sda,
    output logic scl,
    output logic sdaOe
);
    initial begin
        scl = 1'b1;
        sdaOe = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : hw
    // Data moves 4 clocks after SCL falls, so the synced SCL is low first
    task automatic bitx(input logic b, output logic r);
        sdaOe = ~b;
        hw(8);
        scl = 1'b1;
        hw(8);
        r = sda;
        scl = 1'b0;
        hw(4);
    endtask : bitx
    task automatic start();
        sdaOe = 1'b1;
        hw(8);
        scl = 1'b0;
        hw(4);
    endtask : start
    task automatic stop();
        sdaOe = 1'b1;
        hw(8);
        scl = 1'b1;
        hw(8);
        sdaOe = 1'b0;
        hw(16);
    endtask : stop
    // Byte out, returns the acknowledge bit
    task automatic wrByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, ack);
    endtask : wrByte
    // Address or command byte plus two data bytes, MSB first
    task automatic cmd(input logic [7:0] a, input logic [7:0] hi, input logic [7:0] lo,
        output logic nak);
        logic k;
        start();
        wrByte({DEV_ADDR, 1'b0}, nak);
        wrByte(a, k);
        nak = nak | k;
        wrByte(hi, k);
        nak = nak | k;
        wrByte(lo, k);
        nak = nak | k;
        stop();
    endtask : cmd
    // Read n bytes, NACK on the last one
    task automatic rd(input int n, output logic [31:0] d);
        logic k;
        logic r;
        d = '0;
        start();
        wrByte({DEV_ADDR, 1'b1}, k);
        for (int j = 0; j < n; j++) begin
            for (int i = 0; i < 8; i++) begin
                bitx(1'b1, r);
                d = {d[30:0], r};
            end
            bitx(j == n - 1, k);
        end
        stop();
    endtask : rd
endmodule : hsnvm_host

// ==== tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %h got %h", n, e, g); badCount++; end end
module tb;
    import hsnvm_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, scl, hostOe, sdaOut, sdaOe, measDone = 1'b0;
    logic progMode, nvmBusy, nak;
    logic [3:0] humResBits, tempResBits;
    hsnvm_meas_s meas = '0;
    logic [31:0] d;
    int badCount = 0;
    int checks = 0;
    wire logic sda = ~(hostOe | sdaOe);  // Open drain with pull-up
    hsnvm_top #(.LOAD_CYCLES(8), .WRITE_CYCLES(20), .WINDOW_CYCLES(3000)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .meas(meas), .measDone(measDone), .progMode(progMode),
        .nvmBusy(nvmBusy), .humResBits(humResBits), .tempResBits(tempResBits));
    hsnvm_host u_host (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sdaOe(hostOe));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // Bounded wait; a stuck busy shows up as a mismatch
    task automatic waitIdle();
        int i;
        i = 0;
        while (nvmBusy !== 1'b0 && i < 100) begin
            @(negedge clk_sys);
            i++;
        end
        `CHK("busy", 1'b0, nvmBusy);
    endtask : waitIdle
    task automatic regRd(input logic [7:0] a, output logic [15:0] w);
        u_host.cmd(a, CMD_ARG, CMD_ARG, nak);
        waitIdle();
        u_host.rd(3, d);
        `CHK("status", 8'h02, d[23:16]);
        w = d[15:0];
    endtask : regRd
    task automatic testEnterId();
        logic [15:0] w;
        `CHK("hum bits", RES_BITS_14, humResBits);
        `CHK("temp bits", RES_BITS_14, tempResBits);
        u_host.cmd(CMD_ENTER, CMD_ARG, CMD_ARG, nak);
        `CHK("ack", 1'b0, nak);
        waitIdle();
        `CHK("mode", 1'b1, progMode);
        `CHK("sda out", 1'b0, sdaOut);
        regRd(REG_ID_HI, w);
        `CHK("id hi", 16'h5a3c, w);
        regRd(REG_ID_LO, w);
        `CHK("id lo", 16'h0f1e, w);
    endtask : testEnterId
    // Read, edit the field only, write back, for every humidity code and one temperature code
    task automatic testRes();
        logic [15:0] w, n;
        logic [3:0] bits [4] = '{RES_BITS_8, RES_BITS_10, RES_BITS_12, RES_BITS_14};
        regRd(REG_HUM_RD, w);
        `CHK("hum word", 16'h0c00, w);
        for (int c = 0; c < 4; c++) begin
            n = w;
            n[11:10] = c[1:0];
            u_host.cmd(REG_HUM_WR, n[15:8], n[7:0], nak);
            waitIdle();
            `CHK("hum bits", bits[c], humResBits);
            `CHK("temp bits", RES_BITS_14, tempResBits);
            regRd(REG_HUM_RD, w);
            `CHK("hum back", n, w);
        end
        regRd(REG_TEMP_RD, w);
        `CHK("temp word", 16'h0c00, w);
        w[11:10] = 2'h1;
        u_host.cmd(REG_TEMP_WR, w[15:8], w[7:0], nak);
        `CHK("busy on", 1'b1, nvmBusy);
        waitIdle();
        `CHK("temp bits", RES_BITS_10, tempResBits);
        `CHK("hum kept", RES_BITS_14, humResBits);
    endtask : testRes
    // Leave the mode, then fetch a full result and a stale one
    task automatic testExitMeas();
        u_host.cmd(CMD_EXIT, CMD_ARG, CMD_ARG, nak);
        waitIdle();
        `CHK("mode", 1'b0, progMode);
        meas = '{hum: 14'h1234, temp: 14'h2dcb};
        @(negedge clk_sys) measDone = 1'b1;
        @(negedge clk_sys) measDone = 1'b0;
        u_host.rd(4, d);
        `CHK("result", {2'b00, 14'h1234, 14'h2dcb, 2'b00}, d);
        `CHK("hum pct", 28, d[29:16] * 100 / 16383);
        `CHK("temp degc", 78, d[15:2] * 165 / 16383 - 40);
        u_host.rd(1, d);
        `CHK("stale", MEAS_STALE, d[7:6]);
        // Window has long closed, so a fresh entry must be refused
        u_host.cmd(CMD_ENTER, CMD_ARG, CMD_ARG, nak);
        `CHK("late entry", 1'b0, progMode);
    endtask : testExitMeas
    task automatic printVerdict();
        if (badCount == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : printVerdict
    // Whole run needs about 20000 cycles
    initial begin
        repeat (100000) @(posedge clk_sys);
        badCount++;
        printVerdict();
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        testEnterId();
        testRes();
        testExitMeas();
        printVerdict();
    end
endmodule : tb
